// >>> common/okb_pkg.sv
package okb_pkg;

  // ****************************************************************
  // Register map (byte offsets on the block's MMIO port)
  // ****************************************************************
  localparam logic [7:0] OFS_CONTROL     = 8'h00;
  localparam logic [7:0] OFS_ALPHA_CLEAR = 8'h04;
  localparam logic [7:0] OFS_ALPHA_SET   = 8'h08;
  localparam logic [7:0] OFS_MATCH       = 8'h0c;
  localparam logic [7:0] OFS_IGNORE      = 8'h10;
  localparam logic [7:0] OFS_LIMITS      = 8'h14;
  localparam logic [7:0] OFS_PIC_OFFSET  = 8'h18;
  localparam logic [7:0] OFS_PIC_SPAN    = 8'h1c;
  localparam logic [7:0] OFS_STATUS      = 8'h20;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int CTL_EXT_EN   = 0;
  localparam int CTL_FINE_EN  = 1;
  localparam int CTL_KEY_EN   = 2;
  localparam int CTL_CLIP_EN  = 3;
  localparam int CTL_OVL_PRES = 4;
  localparam int CTL_MODE_LO  = 8;
  localparam int IGN_LUMA_LO  = 0;
  localparam int IGN_CHROMA_LO = 8;
  localparam int LIM_LUMA_FLOOR   = 0;
  localparam int LIM_LUMA_CEIL    = 8;
  localparam int LIM_CHROMA_FLOOR = 16;
  localparam int LIM_CHROMA_CEIL  = 24;
  localparam int PIC_X_LO = 0;
  localparam int PIC_Y_LO = 16;

  // Writable bits; all others read back as zero
  localparam logic [31:0] MASK_CONTROL = 32'h00000f1f;
  localparam logic [31:0] MASK_ALPHA   = 32'h000000ff;
  localparam logic [31:0] MASK_MATCH   = 32'h00ffffff;
  localparam logic [31:0] MASK_IGNORE  = 32'h00000707;
  localparam logic [31:0] MASK_PIC     = 32'h0fff0fff;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [31:0] RST_CONTROL = 32'h00000000;
  localparam logic [7:0]  RST_ALPHA   = 8'h00;
  localparam logic [23:0] RST_MATCH   = 24'h000000;
  localparam logic [31:0] RST_IGNORE  = 32'h00000000;
  localparam logic [31:0] RST_LIMITS  = 32'hf010eb10;
  localparam logic [31:0] RST_PIC     = 32'h00000000;

  // ****************************************************************
  // Pixel arithmetic constants
  // ****************************************************************
  localparam logic [7:0] FIXED_FLOOR = 8'h10;
  localparam logic [7:0] FIXED_CEIL  = 8'hf0;
  localparam logic [7:0] FULL_WEIGHT = 8'h80;
  localparam logic [2:0] MAX_IGNORE  = 3'h4;
  localparam int COORD_W    = 12;
  localparam int FIFO_DEPTH = 32;
  localparam int STATUS_LVL_W = 8;

endpackage : okb_pkg

// >>> hw/okb_fifo.sv
`timescale 1ns/1ps
module okb_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic               ref_clk,
  input  wire logic               rst,
  // Fill side
  input  wire logic               wr_valid,
  output logic                    wr_ready,
  input  wire logic [WIDTH-1:0]   wr_data,
  // Drain side
  output logic                    rd_valid,
  input  wire logic               rd_ready,
  output logic [WIDTH-1:0]        rd_data,
  // Fill level
  output logic [$clog2(DEPTH):0]  level
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0]   count;
    logic          ready;
  } okb_fifo_state_t;

  okb_fifo_state_t st_q;
  okb_fifo_state_t st_d;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  assign push     = wr_valid && st_q.ready;
  assign pop      = rd_valid && rd_ready;
  assign rd_valid = (st_q.count != '0);
  assign rd_data  = mem[st_q.rd_ptr];
  assign wr_ready = st_q.ready;
  assign level    = st_q.count;

  always_comb begin
    st_d = st_q;
    if (push) begin
      st_d.wr_ptr = (st_q.wr_ptr == AW'(DEPTH - 1)) ? '0 : st_q.wr_ptr + 1'b1;
    end
    if (pop) begin
      st_d.rd_ptr = (st_q.rd_ptr == AW'(DEPTH - 1)) ? '0 : st_q.rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      st_d.count = st_q.count + 1'b1;
    end else if (pop && !push) begin
      st_d.count = st_q.count - 1'b1;
    end
    // Registered so the fill-side ready never ripples from the drain side
    st_d.ready = (st_d.count != (AW+1)'(DEPTH));
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_q <= '{wr_ptr: '0, rd_ptr: '0, count: '0, ready: 1'b1};
    end else begin
      st_q <= st_d;
    end
  end

  // Storage needs no reset; only words already written are ever read
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[st_q.wr_ptr] <= wr_data;
    end
  end

endmodule : okb_fifo

// >>> hw/okb_compositor.sv
`timescale 1ns/1ps
module okb_compositor #(
  parameter int FIFO_DEPTH = okb_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic                       ref_clk,
  input  wire logic                       rst,
  // Register port
  input  wire logic                       mmio_wr,
  input  wire logic                       mmio_rd,
  input  wire logic [7:0]                 mmio_addr,
  input  wire logic [31:0]                mmio_wdata,
  output logic [31:0]                     mmio_rdata,
  // Pixel pair in
  input  wire logic                       in_valid,
  output logic                            in_ready,
  input  wire logic [7:0]                 bg_y0,
  input  wire logic [7:0]                 bg_y1,
  input  wire logic [7:0]                 bg_u,
  input  wire logic [7:0]                 bg_v,
  input  wire logic [7:0]                 ov_y0,
  input  wire logic [7:0]                 ov_y1,
  input  wire logic [7:0]                 ov_u,
  input  wire logic [7:0]                 ov_v,
  input  wire logic                       ov_here,
  input  wire logic [okb_pkg::COORD_W-1:0] pix_x,
  input  wire logic [okb_pkg::COORD_W-1:0] pix_y,
  // Pixel pair out
  output logic                            out_valid,
  input  wire logic                       out_ready,
  output logic [7:0]                      out_y0,
  output logic [7:0]                      out_y1,
  output logic [7:0]                      out_u,
  output logic [7:0]                      out_v
);
  import okb_pkg::*;

  // ****************************************************************
  // Types and state
  // ****************************************************************
  localparam int FW = 65 + 2 * COORD_W;
  localparam int LW = $clog2(FIFO_DEPTH) + 1;

  typedef struct packed {
    logic [7:0] y0;
    logic [7:0] y1;
    logic [7:0] u;
    logic [7:0] v;
  } okb_pair_t;

  typedef struct packed {
    okb_pair_t            bg;
    okb_pair_t            ov;
    logic                 here;
    logic [COORD_W-1:0]   x;
    logic [COORD_W-1:0]   y;
  } okb_item_t;

  typedef struct packed {
    logic [31:0] control;
    logic [7:0]  alpha_level_bit_clear;
    logic [7:0]  alpha_level_bit_set;
    logic [23:0] transparency_match;
    logic [31:0] match_ignore_bits;
    logic [31:0] output_limits;
    logic [31:0] picture_offset;
    logic [31:0] picture_span;
    logic [31:0] rdata;
    logic        s1_valid;
    okb_pair_t   s1_pix;
    logic        s1_in_area;
    logic        s2_valid;
    okb_pair_t   s2_pix;
  } okb_state_t;

  localparam okb_state_t RST_STATE = '{
    control:               RST_CONTROL,
    alpha_level_bit_clear: RST_ALPHA,
    alpha_level_bit_set:   RST_ALPHA,
    transparency_match:    RST_MATCH,
    match_ignore_bits:     RST_IGNORE,
    output_limits:         RST_LIMITS,
    picture_offset:        RST_PIC,
    picture_span:          RST_PIC,
    rdata:                 32'h00000000,
    s1_valid:              1'b0,
    s1_pix:                '0,
    s1_in_area:            1'b0,
    s2_valid:              1'b0,
    s2_pix:                '0
  };

  okb_state_t st_q;
  okb_state_t st_d;

  // ****************************************************************
  // Pixel functions
  // ****************************************************************
  // Maps an 8-bit alpha level to a weight out of 128
  function automatic logic [7:0] okb_weight(input logic [7:0] lvl,
                                            input logic       fine);
    if (lvl[7]) begin
      okb_weight = FULL_WEIGHT;
    end else if (fine) begin
      okb_weight = {1'b0, lvl[6:0]};
    end else begin
      // Coarse path keeps only level bits 6:5: 0/25/50/75 %
      okb_weight = {1'b0, lvl[6:5], 5'h00};
    end
  endfunction : okb_weight

  // Weighted mix; truncates, so a 50 % mix of odd sums rounds down
  function automatic logic [7:0] okb_blend(input logic [7:0] ov,
                                           input logic [7:0] bg,
                                           input logic [7:0] w);
    logic [15:0] acc;
    acc = 16'(ov) * 16'(w) + 16'(bg) * 16'(FULL_WEIGHT - w);
    okb_blend = acc[14:7];
  endfunction : okb_blend

  // Compares with the given number of low bits ignored, capped at four
  function automatic logic okb_match(input logic [7:0] val,
                                     input logic [7:0] key,
                                     input logic [2:0] ign);
    logic [2:0] n;
    logic [7:0] m;
    n = (ign > MAX_IGNORE) ? MAX_IGNORE : ign;
    m = 8'hff << n;
    okb_match = ((val & m) == (key & m));
  endfunction : okb_match

  function automatic logic [7:0] okb_clamp(input logic [7:0] val,
                                           input logic [7:0] lo,
                                           input logic [7:0] hi);
    if (val <= lo) begin
      okb_clamp = lo;
    end else if (val >= hi) begin
      okb_clamp = hi;
    end else begin
      okb_clamp = val;
    end
  endfunction : okb_clamp

  function automatic logic okb_inside(input logic [COORD_W-1:0] p,
                                      input logic [COORD_W-1:0] off,
                                      input logic [COORD_W-1:0] span);
    logic [COORD_W:0] end_p;
    end_p = {1'b0, off} + {1'b0, span};
    okb_inside = (p >= off) && ({1'b0, p} < end_p);
  endfunction : okb_inside

  // ****************************************************************
  // Input buffer
  // ****************************************************************
  okb_item_t        fifo_in;
  okb_item_t        fifo_out;
  logic [FW-1:0]    fifo_rd_data;
  logic             fifo_rd_valid;
  logic             fifo_wr_ready;
  logic [LW-1:0]    fifo_level;
  logic             advance;

  assign fifo_in  = '{bg: '{y0: bg_y0, y1: bg_y1, u: bg_u, v: bg_v},
                      ov: '{y0: ov_y0, y1: ov_y1, u: ov_u, v: ov_v},
                      here: ov_here, x: pix_x, y: pix_y};
  assign fifo_out = okb_item_t'(fifo_rd_data);
  // Whole pipe moves together; a stalled sink backs up into the buffer
  assign advance  = !st_q.s2_valid || out_ready;

  okb_fifo #(
    .WIDTH (FW),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .wr_valid (in_valid),
    .wr_ready (fifo_wr_ready),
    .wr_data  (FW'(fifo_in)),
    .rd_valid (fifo_rd_valid),
    .rd_ready (advance),
    .rd_data  (fifo_rd_data),
    .level    (fifo_level)
  );

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    logic       ext_en;
    logic       fine;
    logic       key_on;
    logic       refresh;
    logic       compose;
    logic [7:0] lvl0;
    logic [7:0] lvl1;
    logic [7:0] w0;
    logic [7:0] w1;
    logic [2:0] ign_y;
    logic [2:0] ign_c;
    logic       chroma_hit;
    logic       key0;
    logic       key1;
    logic       area;
    logic [7:0] lo_y;
    logic [7:0] hi_y;
    logic [7:0] lo_c;
    logic [7:0] hi_c;
    logic [31:0] rd_val;
    ext_en     = st_q.control[CTL_EXT_EN];
    fine       = ext_en && st_q.control[CTL_FINE_EN];
    key_on     = ext_en && st_q.control[CTL_KEY_EN];
    refresh    = !st_q.control[CTL_MODE_LO+3] &&
                 (st_q.control[CTL_MODE_LO+1 -: 2] != 2'h3);
    compose    = st_q.control[CTL_OVL_PRES] && refresh;
    ign_y      = st_q.match_ignore_bits[IGN_LUMA_LO +: 3];
    ign_c      = st_q.match_ignore_bits[IGN_CHROMA_LO +: 3];
    lvl0       = 8'h00;
    lvl1       = 8'h00;
    w0         = 8'h00;
    w1         = 8'h00;
    chroma_hit = 1'b0;
    key0       = 1'b0;
    key1       = 1'b0;
    area       = 1'b0;
    lo_y       = FIXED_FLOOR;
    hi_y       = FIXED_CEIL;
    lo_c       = FIXED_FLOOR;
    hi_c       = FIXED_CEIL;
    rd_val     = 32'h00000000;
    st_d       = st_q;

    // Register writes; undefined bits are dropped so they read as zero
    if (mmio_wr) begin
      case (mmio_addr)
        OFS_CONTROL:     st_d.control = mmio_wdata & MASK_CONTROL;
        OFS_ALPHA_CLEAR: st_d.alpha_level_bit_clear = mmio_wdata[7:0];
        OFS_ALPHA_SET:   st_d.alpha_level_bit_set = mmio_wdata[7:0];
        OFS_MATCH:       st_d.transparency_match = mmio_wdata[23:0];
        OFS_IGNORE:      st_d.match_ignore_bits = mmio_wdata & MASK_IGNORE;
        OFS_LIMITS:      st_d.output_limits = mmio_wdata;
        OFS_PIC_OFFSET:  st_d.picture_offset = mmio_wdata & MASK_PIC;
        OFS_PIC_SPAN:    st_d.picture_span = mmio_wdata & MASK_PIC;
        default:         st_d.control = st_q.control;
      endcase
    end

    // Register reads, answered one cycle later
    if (mmio_rd) begin
      case (mmio_addr)
        OFS_CONTROL:     rd_val = st_q.control;
        OFS_ALPHA_CLEAR: rd_val = {24'h000000, st_q.alpha_level_bit_clear};
        OFS_ALPHA_SET:   rd_val = {24'h000000, st_q.alpha_level_bit_set};
        OFS_MATCH:       rd_val = {8'h00, st_q.transparency_match};
        OFS_IGNORE:      rd_val = st_q.match_ignore_bits;
        OFS_LIMITS:      rd_val = st_q.output_limits;
        OFS_PIC_OFFSET:  rd_val = st_q.picture_offset;
        OFS_PIC_SPAN:    rd_val = st_q.picture_span;
        OFS_STATUS:      rd_val = {22'h000000, st_q.s2_valid, st_q.s1_valid,
                                   STATUS_LVL_W'(fifo_level)};
        default:         rd_val = 32'h00000000;
      endcase
      st_d.rdata = rd_val;
    end

    // Stage 1: keying and blending
    if (advance) begin
      st_d.s1_valid = fifo_rd_valid;
      if (fifo_rd_valid) begin
        lvl0 = fifo_out.ov.u[0] ? st_q.alpha_level_bit_set
                                : st_q.alpha_level_bit_clear;
        lvl1 = fifo_out.ov.v[0] ? st_q.alpha_level_bit_set
                                : st_q.alpha_level_bit_clear;
        w0 = okb_weight(lvl0, fine);
        w1 = okb_weight(lvl1, fine);
        // Alpha LSBs take part in the key compare like any other bit
        chroma_hit =
          okb_match(fifo_out.ov.u, st_q.transparency_match[15:8], ign_c) &&
          okb_match(fifo_out.ov.v, st_q.transparency_match[23:16], ign_c);
        key0 = key_on && chroma_hit &&
               okb_match(fifo_out.ov.y0, st_q.transparency_match[7:0],
                         ign_y);
        key1 = key_on && chroma_hit &&
               okb_match(fifo_out.ov.y1, st_q.transparency_match[7:0],
                         ign_y);
        if (!compose || !fifo_out.here || key0) begin
          w0 = 8'h00;
        end
        if (!compose || !fifo_out.here || key1) begin
          w1 = 8'h00;
        end
        st_d.s1_pix.y0 = okb_blend(fifo_out.ov.y0, fifo_out.bg.y0, w0);
        st_d.s1_pix.u  = okb_blend(fifo_out.ov.u, fifo_out.bg.u, w0);
        st_d.s1_pix.v  = okb_blend(fifo_out.ov.v, fifo_out.bg.v, w0);
        st_d.s1_pix.y1 = okb_blend(fifo_out.ov.y1, fifo_out.bg.y1,
                                   w1);
        area = okb_inside(fifo_out.x,
                          st_q.picture_offset[PIC_X_LO +: COORD_W],
                          st_q.picture_span[PIC_X_LO +: COORD_W]) &&
               okb_inside(fifo_out.y,
                          st_q.picture_offset[PIC_Y_LO +: COORD_W],
                          st_q.picture_span[PIC_Y_LO +: COORD_W]);
        st_d.s1_in_area = area;
      end
    end

    // Stage 2: range limiting, always after blending
    if (advance) begin
      st_d.s2_valid = st_q.s1_valid;
      if (ext_en && st_q.control[CTL_CLIP_EN]) begin
        lo_y = st_q.output_limits[LIM_LUMA_FLOOR +: 8];
        hi_y = st_q.output_limits[LIM_LUMA_CEIL +: 8];
        lo_c = st_q.output_limits[LIM_CHROMA_FLOOR +: 8];
        hi_c = st_q.output_limits[LIM_CHROMA_CEIL +: 8];
      end
      // Fixed 16..240 otherwise; 0/255 limits make clamping a no-op
      if (st_q.s1_in_area) begin
        st_d.s2_pix.y0 = okb_clamp(st_q.s1_pix.y0, lo_y, hi_y);
        st_d.s2_pix.y1 = okb_clamp(st_q.s1_pix.y1, lo_y, hi_y);
        st_d.s2_pix.u  = okb_clamp(st_q.s1_pix.u, lo_c, hi_c);
        st_d.s2_pix.v  = okb_clamp(st_q.s1_pix.v, lo_c, hi_c);
      end else begin
        st_d.s2_pix = st_q.s1_pix;
      end
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_q <= RST_STATE;
    end else begin
      st_q <= st_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign in_ready   = fifo_wr_ready;
  assign mmio_rdata = st_q.rdata;
  assign out_valid  = st_q.s2_valid;
  assign out_y0     = st_q.s2_pix.y0;
  assign out_y1     = st_q.s2_pix.y1;
  assign out_u      = st_q.s2_pix.u;
  assign out_v      = st_q.s2_pix.v;

endmodule : okb_compositor

// >>> tb/okb_checker.sv
`timescale 1ns/1ps
module okb_checker #(
  parameter int FIFO_DEPTH = 32
) (
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        rst,
  // Register port
  input wire logic        mmio_wr,
  input wire logic        mmio_rd,
  input wire logic [7:0]  mmio_addr,
  input wire logic [31:0] mmio_wdata,
  input wire logic [31:0] mmio_rdata,
  // Pixel handshakes and data
  input wire logic        in_valid,
  input wire logic        in_ready,
  input wire logic        out_valid,
  input wire logic        out_ready,
  input wire logic [7:0]  out_y0,
  input wire logic [7:0]  out_y1,
  input wire logic [7:0]  out_u,
  input wire logic [7:0]  out_v
);
  import okb_pkg::*;
  // Pairs held anywhere inside the block, FIFO and stages alike
  int cnt;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt <= 0;
    end else begin
      cnt <= cnt + int'(in_valid && in_ready) - int'(out_valid && out_ready);
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  chk_stall_hold: assert property (
    out_valid && !out_ready |=> out_valid
      && $stable({out_y0, out_y1, out_u, out_v}))
    else $error("Output pair changed while stalled");
  chk_reset_idle: assert property ($fell(rst) |-> !out_valid && in_ready)
    else $error("Pipe not idle after reset");
  chk_out_source: assert property (out_valid |-> cnt > 0)
    else $error("Output pair without input pair");
  chk_full_depth: assert property (!in_ready |-> cnt >= FIFO_DEPTH)
    else $error("Input refused before buffer full");
  chk_unmapped_zero: assert property (
    mmio_rd && mmio_addr == 8'h24 |=> mmio_rdata == 32'h0)
    else $error("Unmapped read not zero");
  chk_rdata_hold: assert property (!mmio_rd |=> $stable(mmio_rdata))
    else $error("Read data moved without read");
  chk_ctl_undef: assert property (
    mmio_rd && mmio_addr == OFS_CONTROL |=>
      (mmio_rdata & ~MASK_CONTROL) == 32'h0)
    else $error("Undefined control bits read nonzero");
  chk_limits_back: assert property (
    mmio_wr && mmio_addr == OFS_LIMITS ##1 mmio_rd
      && mmio_addr == OFS_LIMITS |=> mmio_rdata == $past(mmio_wdata, 2))
    else $error("Limits readback wrong");
  chk_alpha_back: assert property (
    mmio_wr && mmio_addr == OFS_ALPHA_CLEAR ##1 mmio_rd
      && mmio_addr == OFS_ALPHA_CLEAR |=>
      mmio_rdata == {24'h0, $past(mmio_wdata[7:0], 2)})
    else $error("Alpha level readback wrong");
endmodule : okb_checker
bind okb_compositor okb_checker #(.FIFO_DEPTH(FIFO_DEPTH)) okb_checker_i (
  .ref_clk, .rst, .mmio_wr, .mmio_rd, .mmio_addr, .mmio_wdata, .mmio_rdata,
  .in_valid, .in_ready, .out_valid, .out_ready, .out_y0, .out_y1, .out_u,
  .out_v);

// >>> tb/okb_sink.sv
`timescale 1ns/1ps
module okb_sink (
  // Clock and stall control
  input  wire logic ref_clk,
  input  wire logic hold,
  // Pixel pair handshake
  output logic      out_ready
);
  // Random stalls exercise the back-pressure path
  always @(negedge ref_clk) begin
    out_ready <= !hold && $urandom_range(3) != 0;
  end
endmodule : okb_sink

// >>> tb/tb.sv
`timescale 1ns/1ps
module tb;
  import okb_pkg::*;
  logic ref_clk = 0, rst = 1, mmio_wr = 0, mmio_rd = 0, hold = 0;
  logic in_valid = 0, ov_here = 0, in_ready, out_valid, out_ready;
  logic [7:0] mmio_addr = 0, out_y0, out_y1, out_u, out_v;
  logic [11:0] pix_x = 0, pix_y = 0;
  logic [31:0] mmio_wdata = 0, bg = 0, ov = 0, mmio_rdata, regs[9], q[$];
  logic [31:0] cfg[8] = '{32'h13, 32'h11, 32'h16, 32'h17, 32'h1b,
                          32'h03, 32'h313, 32'h81f};
  logic [7:0] lv[5] = '{8'h00, 8'h40, 8'h7f, 8'h80, 8'hff};
  int miscompares = 0, n_compared = 0, n, i;
  okb_compositor okb_compositor_i (
    .ref_clk, .rst, .mmio_wr, .mmio_rd, .mmio_addr, .mmio_wdata, .mmio_rdata,
    .in_valid, .in_ready, .bg_y0(bg[31:24]), .bg_y1(bg[23:16]),
    .bg_u(bg[15:8]), .bg_v(bg[7:0]), .ov_y0(ov[31:24]), .ov_y1(ov[23:16]),
    .ov_u(ov[15:8]), .ov_v(ov[7:0]), .ov_here, .pix_x, .pix_y, .out_valid,
    .out_ready, .out_y0, .out_y1, .out_u, .out_v);
  okb_sink okb_sink_i (.ref_clk, .hold, .out_ready);
  initial begin
    forever #4 ref_clk = ~ref_clk;
  end
  // ****************************************
  // Checking and expected values
  // ****************************************
  task automatic complete_run;
    $display("Compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : complete_run
  task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  function automatic logic [7:0] wt(logic b);
    logic [7:0] l;
    l = b ? regs[2][7:0] : regs[1][7:0];
    if (l[7]) return 8'h80;
    if (regs[0][1:0] == 2'h3) return {1'b0, l[6:0]};
    return {1'b0, l[6:5], 5'h0};
  endfunction : wt
  function automatic logic km(logic [23:0] p);
    logic [2:0] a, c;
    a = (regs[4][2:0] > 3'h4) ? 3'h4 : regs[4][2:0];
    c = (regs[4][10:8] > 3'h4) ? 3'h4 : regs[4][10:8];
    return regs[0][0] && regs[0][2] &&
      ((p ^ regs[3][23:0]) & {8'hff << c, 8'hff << c, 8'hff << a}) == 0;
  endfunction : km
  function automatic logic [7:0] mx(logic [7:0] o, b, w, logic a, ch);
    logic [15:0] r;
    logic [31:0] l;
    r = (16'(o) * w + 16'(b) * (16'h80 - w)) >> 7;
    l = (regs[0][0] && regs[0][3]) ? regs[5] : 32'hf010f010;
    if (ch) l = l >> 16;
    if (a && r <= l[7:0]) r = l[7:0];
    else if (a && r >= l[15:8]) r = l[15:8];
    return r[7:0];
  endfunction : mx
  function automatic logic [31:0] ex();
    logic [7:0] w0, w1;
    logic en, a;
    en = ov_here && regs[0][4] && !regs[0][11] && regs[0][9:8] != 3;
    w0 = (en && !km({ov[7:0], ov[15:8], ov[31:24]})) ? wt(ov[8]) : 0;
    w1 = (en && !km({ov[7:0], ov[15:8], ov[23:16]})) ? wt(ov[0]) : 0;
    a = pix_x >= regs[6][11:0] && pix_y >= regs[6][27:16]
      && 13'(pix_x) < 13'(regs[6][11:0]) + 13'(regs[7][11:0])
      && 13'(pix_y) < 13'(regs[6][27:16]) + 13'(regs[7][27:16]);
    return {mx(ov[31:24], bg[31:24], w0, a, 0), mx(ov[23:16], bg[23:16], w1,
      a, 0), mx(ov[15:8], bg[15:8], w0, a, 1), mx(ov[7:0], bg[7:0], w0, a, 1)};
  endfunction : ex
  always @(posedge ref_clk) begin
    if (!rst && out_valid === 1'b1 && out_ready === 1'b1) begin
      if (q.size() == 0) begin
        chk("out_valid", 32'h1, 32'h0);
      end else begin
        chk("pair", {out_y0, out_y1, out_u, out_v}, q.pop_front());
      end
    end
  end
  // ****************************************
  // Drivers, entered and left at a falling edge
  // ****************************************
  task automatic rd(logic [7:0] a, logic [31:0] e);
    mmio_rd = 1;
    mmio_addr = a;
    @(negedge ref_clk);
    mmio_rd = 0;
    chk("rdata", mmio_rdata, e);
  endtask : rd
  task automatic wrd(logic [7:0] a, logic [31:0] d, logic [31:0] m);
    mmio_wr = 1;
    mmio_addr = a;
    mmio_wdata = d;
    if (a < OFS_STATUS) regs[a[7:2]] = d & m;
    @(negedge ref_clk);
    mmio_wr = 0;
    rd(a, d & m);
  endtask : wrd
  task automatic send;
    bg = $urandom;
    ov = $urandom;
    if ($urandom_range(1)) ov = {regs[3][7:0], regs[3][7:0], regs[3][15:8],
      regs[3][23:16]} ^ ($urandom & 32'h03030303);
    ov_here = $urandom_range(3) != 0;
    pix_x = 12'($urandom_range(40));
    pix_y = 12'($urandom_range(40));
    in_valid = 1;
    for (i = 0; i < 500 && in_ready !== 1'b1; i++) @(negedge ref_clk);
    if (in_ready !== 1'b1) begin
      chk("in_ready", 32'h0, 32'h1);
      complete_run;
    end
    @(posedge ref_clk);
    q.push_back(ex());
    @(negedge ref_clk);
  endtask : send
  task automatic drain;
    in_valid = 0;
    for (i = 0; i < 3000 && q.size() > 0; i++) @(negedge ref_clk);
    if (q.size() > 0) begin
      chk("drain", 32'(q.size()), 32'h0);
      complete_run;
    end
  endtask : drain
  initial begin
    n = $urandom(32'hdd1ca5a7);
    foreach (regs[k]) regs[k] = 32'h0;
    regs[5] = RST_LIMITS;
    repeat (5) @(posedge ref_clk);
    @(negedge ref_clk);
    rst = 0;
    rd(OFS_LIMITS, RST_LIMITS);
    wrd(8'h24, $urandom, 32'h0);
    wrd(OFS_CONTROL, 32'hffffffff, MASK_CONTROL);
    foreach (cfg[k]) begin
      wrd(OFS_CONTROL, cfg[k], MASK_CONTROL);
      wrd(OFS_ALPHA_CLEAR, k[2] ? $urandom & 255 : lv[$urandom_range(4)],
        MASK_ALPHA);
      wrd(OFS_ALPHA_SET, lv[$urandom_range(4)], MASK_ALPHA);
      wrd(OFS_MATCH, $urandom & MASK_MATCH, MASK_MATCH);
      wrd(OFS_IGNORE, $urandom & MASK_IGNORE, MASK_IGNORE);
      wrd(OFS_LIMITS, k[0] ? 32'hff00ff00 :
        ($urandom & 32'hff7fff7f) | 32'h80008000, 32'hffffffff);
      wrd(OFS_PIC_OFFSET, $urandom & 32'h000f000f, MASK_PIC);
      wrd(OFS_PIC_SPAN, $urandom & 32'h001f001f, MASK_PIC);
      repeat (30) send;
      if (k == 0) begin
        // Empty pipe first, so the fill count sees the whole buffer
        drain;
        hold = 1;
        for (n = 0; in_ready === 1'b1 && n < 40; n++) send;
        chk("fill", 32'(n >= FIFO_DEPTH && n <= FIFO_DEPTH + 3), 32'h1);
        rd(OFS_STATUS, 32'h300 | 32'(FIFO_DEPTH));
        hold = 0;
      end
      drain;
      rd(OFS_STATUS, 32'h0);
      $display("Test %0d done", k);
    end
    complete_run;
  end
endmodule : tb
